// ### ahc_pkg.sv
/*
 * shared constants and pin group types for the converter host controller.
 * assumes a 100 MHz mclk and a converter wired to the pins of the top module.
 */
// ****************************************************************
// Operation
// ****************************************************************
// Operation
// - host holds select low; ready falls then
// - select falls 20ns before read in sampling
// - write falling starts conversion, select low
// - stand-alone: select and read held low; the host raises both again after every request
package ahc_pkg;
    localparam int  CLK_PERIOD_NS   = 10;
    localparam int  POWERUP_NS      = 3000;
    localparam int  POWERUP_CYC     = POWERUP_NS / CLK_PERIOD_NS;
    localparam int  CS_LEAD_NS      = 20;
    localparam int  CS_LEAD_CYC     = (CS_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  WR_LOW_NS       = 170;
    localparam int  WR_LOW_CYC      = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  WR_RD_NS        = 275;
    localparam int  WR_RD_CYC       = (WR_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  TIMEOUT_CYC     = 4000;
    localparam int  CNT_W           = 12;

    typedef enum logic [2:0] {
        ST_POWERUP, ST_IDLE, ST_CS_LEAD, ST_RD_WAIT, ST_WR_LOW,
        ST_WR_GAP, ST_DONE_WAIT, ST_RELEASE
    } ahc_state_type;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic wr_oe;
        logic mode;
    } ahc_pins_type;

    typedef struct packed {
        ahc_state_type     state;
        logic [CNT_W-1:0]  cnt;
        ahc_pins_type      pins;
        logic [7:0]        data;
        logic              valid;
        logic              busy;
        logic              timeout;
        logic              early;
    } ahc_regs_type;
endpackage

// ### ahc_host.sv
/*
 * host controller that drives the converter pins: select, read, write/ready,
 * and reads back the done flag and the result bus. one clock, all outputs registered.
 * assumes the board pulls the ready line up and the result bus is sampled here.
 */
`timescale 1ns/1ps
module ahc_host #(
    parameter int POWERUP_CYCLES = ahc_pkg::POWERUP_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // user request
    input  wire logic        start,
    input  wire logic        wr_rd_mode,
    input  wire logic        early_read,
    input  wire logic        sampling,
    output logic             busy,
    output logic             result_valid,
    output logic [7:0]       result,
    output logic             timeout,
    // converter pins
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic             wr_n_oe,
    input  wire logic        rdy_pin,
    input  wire logic        done_n,
    input  wire logic [7:0]  result_bus,
    output logic             mode_sel,
    output logic             sample_hold_select
);
    // refuse a power-up count that the cycle counter cannot hold
    if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= (1 << ahc_pkg::CNT_W)) begin : g_bad_powerup
        $error("POWERUP_CYCLES out of range");
    end

    // ****************************************************************
    // reset release and pin synchronisers
    // ****************************************************************
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [9:0] pin_s1;
    logic [9:0] pin_s2;
    logic       sh_reg;

    // two flops on release so the whole design leaves reset together
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end
    assign rst_n = rst_sync[1];

    // pins come from the converter's own timing, so two flops before use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 10'h3FF;
            pin_s2 <= 10'h3FF;
            sh_reg <= 1'h0;
        end else begin
            pin_s1 <= {rdy_pin, done_n, result_bus};
            pin_s2 <= pin_s1;
            sh_reg <= sampling;
        end
    end

    logic       rdy_s;
    logic       done_s;
    logic [7:0] bus_s;
    assign rdy_s  = pin_s2[9];
    assign done_s = pin_s2[8];
    assign bus_s  = pin_s2[7:0];

    // ****************************************************************
    // sequencer
    // ****************************************************************
    ahc_pkg::ahc_regs_type st_reg;
    ahc_pkg::ahc_regs_type st_next;

    localparam logic [ahc_pkg::CNT_W-1:0] LEAD_C  = ahc_pkg::CNT_W'(ahc_pkg::CS_LEAD_CYC);
    localparam logic [ahc_pkg::CNT_W-1:0] WRLO_C  = ahc_pkg::CNT_W'(ahc_pkg::WR_LOW_CYC);
    localparam logic [ahc_pkg::CNT_W-1:0] WRRD_C  = ahc_pkg::CNT_W'(ahc_pkg::WR_RD_CYC);
    localparam logic [ahc_pkg::CNT_W-1:0] TOUT_C  = ahc_pkg::CNT_W'(ahc_pkg::TIMEOUT_CYC);

    // one next-state process; pins idle high, write pin driven only in write-then-read
    always_comb begin
        st_next             = st_reg;
        st_next.valid       = 1'h0;
        st_next.cnt         = st_reg.cnt + 1'h1;
        unique case (st_reg.state)
            ahc_pkg::ST_POWERUP: begin
                // converter ignores select during its inhibit, so wait it out
                if (st_reg.cnt >= ahc_pkg::CNT_W'(POWERUP_CYCLES - 1)) begin
                    st_next.state = ahc_pkg::ST_IDLE;
                end
            end
            ahc_pkg::ST_IDLE: begin
                st_next.cnt         = '0;
                st_next.busy        = 1'h0;
                st_next.pins.mode   = wr_rd_mode;
                st_next.pins.wr_oe  = wr_rd_mode;
                st_next.pins.wr_n   = 1'h1;
                if (start) begin
                    st_next.busy    = 1'h1;
                    st_next.timeout = 1'h0;
                    st_next.early   = early_read;
                    st_next.pins.cs_n = 1'h0;
                    st_next.state   = ahc_pkg::ST_CS_LEAD;
                end
            end
            ahc_pkg::ST_CS_LEAD: begin
                // select leads read by the lead time to avoid charge injection
                if (st_reg.cnt >= LEAD_C) begin
                    st_next.cnt = '0;
                    if (st_reg.pins.mode) begin
                        st_next.pins.wr_n = 1'h0;
                        st_next.state     = ahc_pkg::ST_WR_LOW;
                    end else begin
                        st_next.pins.rd_n = 1'h0;
                        st_next.state     = ahc_pkg::ST_RD_WAIT;
                    end
                end
            end
            ahc_pkg::ST_RD_WAIT: begin
                // ready high with the flag low marks the end in read-only mode
                if (rdy_s && !done_s) begin
                    st_next.state = ahc_pkg::ST_DONE_WAIT;
                    st_next.cnt   = '0;
                end else if (st_reg.cnt >= TOUT_C) begin
                    st_next.timeout = 1'h1;
                    st_next.state   = ahc_pkg::ST_RELEASE;
                end
            end
            ahc_pkg::ST_WR_LOW: begin
                // upper nibble decided while write stays low
                if (st_reg.cnt >= WRLO_C) begin
                    st_next.pins.wr_n = 1'h1;
                    st_next.cnt       = '0;
                    st_next.state     = ahc_pkg::ST_WR_GAP;
                end
            end
            ahc_pkg::ST_WR_GAP: begin
                // early read shortens conversion; otherwise wait for the flag
                if (st_reg.early && st_reg.cnt >= WRRD_C) begin
                    st_next.pins.rd_n = 1'h0;
                    st_next.cnt       = '0;
                    st_next.state     = ahc_pkg::ST_DONE_WAIT;
                end else if (!st_reg.early && !done_s) begin
                    st_next.pins.rd_n = 1'h0;
                    st_next.cnt       = '0;
                    st_next.state     = ahc_pkg::ST_DONE_WAIT;
                end else if (st_reg.cnt >= TOUT_C) begin
                    st_next.timeout = 1'h1;
                    st_next.state   = ahc_pkg::ST_RELEASE;
                end
            end
            ahc_pkg::ST_DONE_WAIT: begin
                // bus floats until the flag falls; flag and bus may land in different
                // sync cycles, so the settling count restarts when the flag is first seen low
                if (done_s) begin
                    st_next.early = 1'h1;
                    if (st_reg.cnt >= TOUT_C) begin
                        st_next.timeout = 1'h1;
                        st_next.state   = ahc_pkg::ST_RELEASE;
                    end
                end else if (st_reg.early) begin
                    st_next.early = 1'h0;
                    st_next.cnt   = '0;
                end else if (st_reg.cnt >= 2) begin
                    st_next.data  = bus_s;
                    st_next.valid = 1'h1;
                    st_next.state = ahc_pkg::ST_RELEASE;
                end
            end
            ahc_pkg::ST_RELEASE: begin
                // rising read and select float the bus and clear the flag
                st_next.pins.rd_n = 1'h1;
                st_next.pins.cs_n = 1'h1;
                st_next.state     = ahc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg       <= '0;
            st_reg.state <= ahc_pkg::ST_POWERUP;
            st_reg.busy  <= 1'h1;
            st_reg.pins  <= 5'h1C;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // outputs, all straight from flops
    // ****************************************************************
    assign cs_n               = st_reg.pins.cs_n;
    assign rd_n               = st_reg.pins.rd_n;
    assign wr_n               = st_reg.pins.wr_n;
    assign wr_n_oe            = st_reg.pins.wr_oe;
    assign mode_sel           = st_reg.pins.mode;
    assign sample_hold_select = sh_reg;
    assign busy               = st_reg.busy;
    assign result_valid       = st_reg.valid;
    assign result             = st_reg.data;
    assign timeout            = st_reg.timeout;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_cs_drop;
        $fell(cs_n);
    endsequence

    a_cs_before_rd: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(rd_n) |-> !$past(cs_n, 2)) else $error("read fell without select lead");
    a_rd_only_oe: assert property (@(posedge mclk) disable iff (!rst_n)
        (!mode_sel && st_reg.state != ahc_pkg::ST_POWERUP) |-> !wr_n_oe)
        else $error("write pin driven in read-only mode");
    a_powerup_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_reg.state == ahc_pkg::ST_POWERUP) |-> cs_n) else $error("select during inhibit");
    a_release_both: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_reg.state == ahc_pkg::ST_RELEASE) |=> (cs_n && rd_n))
        else $error("release left strobes low");
    a_start_select: assert property (@(posedge mclk) disable iff (!rst_n)
        s_cs_drop |-> busy) else $error("select fell while idle");
    a_wr_width: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(wr_n) |-> !wr_n [*8]) else $error("write pulse too short");
endmodule

// ### ahc_adc_model.sv
/* behavioural converter seen by the host controller.
   assumes the bench muxes the shared write/ready wire on the write pin enable. */
`timescale 1ns/1ps
// ****************************************************************
// converter model
// ****************************************************************
module ahc_adc_model #(
    parameter int CONV_NS = 500,
    parameter int INTL_NS = 600,
    parameter int RI_NS   = 100,
    parameter int PWR_NS  = 100
) (
    // pins
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       mode,
    output logic            rdy,
    output logic            done_n,
    output logic [7:0]      db,
    // bench control: holds the conversion while high
    input  wire logic       stall
);
    logic       pwr_ok = 1'b0;
    logic       conv   = 1'b0;
    logic       lsb    = 1'b0;
    int         t_ns   = 0;
    int         r_ns   = 0;
    logic [7:0] code   = 8'h5A;
    logic [7:0] latch  = 8'h00;
    // power-up inhibit keeps the flag high and select ignored
    initial done_n = 1'b1;
    initial #PWR_NS pwr_ok = 1'b1;
    // read fall starts a read-only conversion; mode low is read-only
    always @(negedge rd_n) if (pwr_ok && !cs_n && !mode) begin
        conv = 1'b1;
        lsb  = 1'b1;
        t_ns = 0;
    end
    // write fall starts, write rise moves to the low nibble
    always @(negedge wr_n) if (pwr_ok && !cs_n && mode) begin
        conv = 1'b1;
        lsb  = 1'b0;
    end
    always @(posedge wr_n) if (mode) begin
        done_n = 1'b1;
        lsb    = conv;
        t_ns   = 0;
    end
    // rise of read or select ends the read and raises the flag
    always @(posedge rd_n or posedge cs_n) begin
        done_n = 1'b1;
        if (cs_n || !mode) conv = 1'b0;
    end
    // internal timing in 1 ns steps; an early read shortens the wait
    always #1 begin
        t_ns = t_ns + 1;
        r_ns = rd_n ? 0 : r_ns + 1;
        if (conv && lsb && !stall && (mode ? (t_ns >= INTL_NS || r_ns >= RI_NS)
                                            : t_ns >= CONV_NS)) begin
            conv   = 1'b0;
            latch  = code;
            code   = code + 8'h3B;
            done_n = 1'b0;
        end
    end
    // ready driven low or high, and a bus that shows garbage when floating
    assign rdy = (pwr_ok && !mode && !cs_n && done_n) ? 1'b0 : 1'b1;
    assign db  = (!done_n && !rd_n && !cs_n) ? latch : ~latch;
endmodule

// ### ahc_host_test.sv
/* self-checking bench for the converter host controller.
   assumes the converter model answers on the shared pins. */
`timescale 1ns/1ps
// ****************************************************************
// bench top
// ****************************************************************
module adc_host_handshake_control_test;
    typedef struct {logic m; logic e; logic s; int lmin; int lmax;} ahc_row_type;
    logic mclk = 1'b0, resetn = 1'b0, start = 1'b0, stall = 1'b0;
    logic wr_rd_mode = 1'b0, early_read = 1'b0, sampling = 1'b0;
    logic busy, result_valid, timeout, cs_n, rd_n, wr_n, wr_n_oe, done_n, mode_sel, shs, rdy;
    logic [7:0] result, db, exp_code;
    wire        wr_rdy = wr_n_oe ? wr_n : rdy;
    int         n_mismatch = 0, checked = 0, lat;
    // mode, early read, sampling, latency window in cycles
    ahc_row_type rows [4] = '{'{1'b0, 1'b0, 1'b0, 50, 75}, '{1'b0, 1'b0, 1'b1, 50, 75},
                              '{1'b1, 1'b0, 1'b1, 77, 115}, '{1'b1, 1'b1, 1'b0, 55, 76}};
    ahc_host #(.POWERUP_CYCLES(10)) dut_u (.mclk(mclk), .resetn(resetn), .start(start),
        .wr_rd_mode(wr_rd_mode), .early_read(early_read), .sampling(sampling), .busy(busy),
        .result_valid(result_valid), .result(result), .timeout(timeout), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .wr_n_oe(wr_n_oe), .rdy_pin(wr_rdy), .done_n(done_n),
        .result_bus(db), .mode_sel(mode_sel), .sample_hold_select(shs));
    ahc_adc_model adc_u (.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_rdy), .mode(mode_sel),
        .rdy(rdy), .done_n(done_n), .db(db), .stall(stall));
    // free-running 100 MHz clock
    always #5 mclk = ~mclk;
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask
    // bounded wait until the controller is idle again
    task automatic idle_wait();
        int k = 0;
        while (busy !== 1'b0 && k < 1000) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 1000) begin
            n_mismatch++;
            test_done();
        end
    endtask
    // one request; returns the cycles until valid or timeout
    task automatic run(input logic m, input logic e, input logic s, output int cyc);
        @(posedge mclk);
        wr_rd_mode <= m;
        early_read <= e;
        sampling   <= s;
        start      <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        cyc = 0;
        while (result_valid !== 1'b1 && !(timeout === 1'b1 && cyc > 2) && cyc < 4500) begin
            @(negedge mclk);
            cyc++;
        end
        if (cyc >= 4500) begin
            n_mismatch++;
            test_done();
        end
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        resetn   <= 1'b1;
        exp_code = 8'h5A;
        foreach (rows[i]) begin
            idle_wait();
            run(rows[i].m, rows[i].e, rows[i].s, lat);
            check(result, exp_code, "result");
            check(8'(lat >= rows[i].lmin && lat <= rows[i].lmax), 8'h01, "latency");
            check(mode_sel, rows[i].m, "mode pin");
            check(wr_n_oe, rows[i].m, "write pin enable");
            check(shs, rows[i].s, "sample hold select");
            exp_code = exp_code + 8'h3B;
            idle_wait();
            check({cs_n, rd_n, done_n}, 3'h7, "strobes released");
            $display("row %0d done", i);
        end
        // a conversion that never ends must time out, then recover
        stall <= 1'b1;
        run(1'b0, 1'b0, 1'b0, lat);
        check(timeout, 1'b1, "timeout");
        idle_wait();
        stall <= 1'b0;
        run(1'b0, 1'b0, 1'b0, lat);
        check(timeout, 1'b0, "timeout cleared");
        check(result, exp_code, "result after timeout");
        exp_code = exp_code + 8'h3B;
        $display("timeout test done");
        // reset in mid-transfer, then a clean transfer
        idle_wait();
        run(1'b1, 1'b0, 1'b0, lat);
        check(result, exp_code, "write result");
        exp_code = exp_code + 8'h3B;
        idle_wait();
        @(posedge mclk);
        wr_rd_mode <= 1'b1;
        start      <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b0;
        @(negedge mclk);
        check({cs_n, rd_n, wr_n_oe, busy}, 4'hD, "pins in reset");
        @(posedge mclk);
        resetn <= 1'b1;
        idle_wait();
        run(1'b0, 1'b0, 1'b0, lat);
        check(result, exp_code, "result after reset");
        $display("reset test done");
        test_done();
    end
endmodule
